// File: cis_irq_sources.sv
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// R1: External pin detects rising edges when polarity bit is one, falling when zero.
// R2: A valid external pin edge sets the external flag, control bit 1.
// R3: Clearing external enable, control bit 4, stops that flag raising a request.
// R4: Software clears the external flag itself before enabling it again.
// R5: External pin wakes sleep only if its enable was set before sleep.
// R6: After wake, branch to vector only when global enable is set.
// R7: Timer rolling from its maximum to zero sets overflow flag, control bit 2.
// R8: Timer overflow enable, control bit 5, gates the overflow request.
// R9: Any level change on port pins 7 to 4 sets port flag, bit 0.
// R10: A dedicated port change enable bit gates the port change request.
// R11: Taking an interrupt pushes only the return program counter.
// R12: Software saves working register, status and page latch itself.
// R13: Return address stack holds eight entries.
// R14: Request logic serves fourteen interrupt sources in all.
// R15: A taken interrupt loads the program counter with vector 0004h.
// R16: Request is OR of flag-and-enable pairs, gated by global enable.
module cis_irq_sources (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// Register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [7:0]                 reg_rdata,
	// Event sources
	input  wire logic                  ext_irq_pin,
	input  wire logic [7:0]            eight_bit_timer_count,
	input  wire logic [7:4]            upper_nibble_port,
	input  wire logic [10:0]           aux_flags,
	input  wire logic [10:0]           aux_enables,
	// Core sequencer
	input  wire logic                  sleep_enter,
	input  wire logic                  irq_ack,
	input  wire logic                  call_push,
	input  wire logic                  ret_pop,
	input  wire logic [12:0]           return_pc,
	output logic                       irq_req,
	output logic                       wake,
	output logic                       wake_to_vector,
	output logic                       pc_load,
	output logic [12:0]                vector_pc,
	output logic [12:0]                stack_top,
	// Interrupt line to the system
	output logic                       irq_out
);

	typedef struct packed {
		cis_pkg::cis_state_t st;
		logic [7:0]          irq_ctrl;
		logic                edge_pol;
		logic [3:0]          evt_status;
		logic [3:0]          evt_mask;
		logic [7:0]          rdata;
		logic [7:0]          last_timer;
		logic                timer_primed;
		logic [2:0]          sleep_en;
		logic                pc_load;
		logic [12:0]         vector_pc;
	} cis_main_state_t;

	cis_main_state_t       q;
	cis_main_state_t       next_q;
	cis_pkg::cis_regbus_t  bus;
	cis_pkg::cis_core_req_t core;
	logic                  ext_hit;
	logic                  port_hit;
	logic                  timer_ovf;
	logic                  pend_ext;
	logic                  pend_timer;
	logic                  pend_port;
	logic                  pend_aux;
	logic                  any_pend;
	logic                  global_en;
	logic                  wake_cond;
	logic [3:0]            stack_level;

	// Bundle the port signals so decode and sequencing read one carrier each
	assign bus.addr         = reg_addr;
	assign bus.wdata        = reg_wdata;
	assign bus.wr           = reg_wr;
	assign bus.rd           = reg_rd;
	assign core.sleep_enter = sleep_enter;
	assign core.irq_ack     = irq_ack;
	assign core.call_push   = call_push;
	assign core.ret_pop     = ret_pop;
	assign core.pc          = return_pc;

	// External pin edge, direction picked by the polarity bit
	cis_change_detect #(
		.W(1)
	) u_ext_edge (
		.clk     (clk),
		.reset   (reset),
		.sig     (ext_irq_pin),
		.rise_en (q.edge_pol),  // R1
		.fall_en (~q.edge_pol), // R1
		.hit     (ext_hit)
	);

	// Upper nibble port, any change in either direction counts
	cis_change_detect #(
		.W(4)
	) u_port_change (
		.clk     (clk),
		.reset   (reset),
		.sig     (upper_nibble_port),
		.rise_en (1'b1), // R9
		.fall_en (1'b1), // R9
		.hit     (port_hit)
	);

	// Return addresses only; working register and status stay with software
	cis_return_stack u_stack (
		.clk       (clk),
		.reset     (reset),
		.push      (core.irq_ack | core.call_push), // R11
		.pop       (core.ret_pop),
		.push_data (core.pc),                       // R11
		.top       (stack_top),
		.level     (stack_level)
	);

	// Rollover seen between two consecutive timer samples
	assign timer_ovf = q.timer_primed & (q.last_timer == cis_pkg::TIMER_MAX)
		& (eight_bit_timer_count == cis_pkg::TIMER_ZERO); // R7

	// Each flag paired with its own enable
	assign global_en  = q.irq_ctrl[cis_pkg::BIT_GLOBAL_EN];
	assign pend_ext   = q.irq_ctrl[cis_pkg::BIT_EXT_FLAG] & q.irq_ctrl[cis_pkg::BIT_EXT_EN];       // R3
	assign pend_timer = q.irq_ctrl[cis_pkg::BIT_TIMER_FLAG] & q.irq_ctrl[cis_pkg::BIT_TIMER_EN];   // R8
	assign pend_port  = q.irq_ctrl[cis_pkg::BIT_PORT_FLAG] & q.irq_ctrl[cis_pkg::BIT_PORT_EN];     // R10
	assign pend_aux   = |(aux_flags & aux_enables);                                                // R14
	assign any_pend   = pend_ext | pend_timer | pend_port | pend_aux;

	// Request to the core; flags latch regardless, only the request is gated
	assign irq_req = global_en & any_pend; // R16

	// Wake uses enables captured at sleep entry, so enabling late does not wake
	assign wake_cond = (q.irq_ctrl[cis_pkg::BIT_EXT_FLAG] & q.sleep_en[0])
		| (q.irq_ctrl[cis_pkg::BIT_TIMER_FLAG] & q.sleep_en[1])
		| (q.irq_ctrl[cis_pkg::BIT_PORT_FLAG] & q.sleep_en[2]); // R5

	// Handshake outputs straight from state
	assign wake           = (q.st == cis_pkg::ST_WAKE);
	assign wake_to_vector = wake & global_en; // R6
	assign pc_load        = q.pc_load;
	assign vector_pc      = q.vector_pc;
	assign reg_rdata      = q.rdata;
	assign irq_out        = |(q.evt_status & q.evt_mask);

	// Next state: register port, flag setting, sleep sequencing and vectoring
	always_comb begin
		next_q = q;

		// Timer history for rollover detection
		next_q.last_timer   = eight_bit_timer_count;
		next_q.timer_primed = 1'b1;

		// Register writes; software may clear flags, hardware sets below win
		if (bus.wr) begin
			case (bus.addr)
				cis_pkg::ADDR_IRQ_CTRL: begin
					next_q.irq_ctrl = bus.wdata;
				end
				cis_pkg::ADDR_OPTION: begin
					next_q.edge_pol = bus.wdata[cis_pkg::BIT_EDGE_POL];
				end
				cis_pkg::ADDR_EVT_MASK: begin
					next_q.evt_mask = bus.wdata[3:0];
				end
				default: begin
				end
			endcase
		end

		// Taking an interrupt drops the global enable to block nesting
		if (core.irq_ack) begin
			next_q.irq_ctrl[cis_pkg::BIT_GLOBAL_EN] = 1'b0;
		end

		// Hardware flag sets, applied after any software clear
		if (ext_hit) begin
			next_q.irq_ctrl[cis_pkg::BIT_EXT_FLAG] = 1'b1; // R2
		end
		if (timer_ovf) begin
			next_q.irq_ctrl[cis_pkg::BIT_TIMER_FLAG] = 1'b1; // R7
		end
		if (port_hit) begin
			next_q.irq_ctrl[cis_pkg::BIT_PORT_FLAG] = 1'b1; // R9
		end

		// Read data, registered for the cycle after the strobe
		next_q.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				cis_pkg::ADDR_IRQ_CTRL: begin
					next_q.rdata = q.irq_ctrl;
				end
				cis_pkg::ADDR_OPTION: begin
					next_q.rdata = {1'b0, q.edge_pol, 6'h00};
				end
				cis_pkg::ADDR_EVT_STATUS: begin
					next_q.rdata = {4'h0, q.evt_status};
				end
				cis_pkg::ADDR_EVT_MASK: begin
					next_q.rdata = {4'h0, q.evt_mask};
				end
				cis_pkg::ADDR_CORE_STATE: begin
					next_q.rdata = {1'b0, q.st, stack_level};
				end
				default: begin
					next_q.rdata = 8'h00;
				end
			endcase
		end

		// Sticky event status: read clears, a same-cycle event survives
		if (bus.rd && (bus.addr == cis_pkg::ADDR_EVT_STATUS)) begin
			next_q.evt_status = 4'h0;
		end
		next_q.evt_status[cis_pkg::EVT_EXT]   = next_q.evt_status[cis_pkg::EVT_EXT] | ext_hit;
		next_q.evt_status[cis_pkg::EVT_TIMER] = next_q.evt_status[cis_pkg::EVT_TIMER] | timer_ovf;
		next_q.evt_status[cis_pkg::EVT_PORT]  = next_q.evt_status[cis_pkg::EVT_PORT] | port_hit;
		next_q.evt_status[cis_pkg::EVT_WAKE]  = next_q.evt_status[cis_pkg::EVT_WAKE] | (q.st == cis_pkg::ST_WAKE);

		// Vector load follows an accepted interrupt by one cycle
		next_q.pc_load = core.irq_ack; // R15
		if (core.irq_ack) begin
			next_q.vector_pc = cis_pkg::IRQ_VECTOR; // R15
		end

		// Sleep sequencer
		case (q.st)
			cis_pkg::ST_RUN: begin
				if (core.sleep_enter) begin
					next_q.st       = cis_pkg::ST_SLEEP;
					next_q.sleep_en = {q.irq_ctrl[cis_pkg::BIT_PORT_EN], q.irq_ctrl[cis_pkg::BIT_TIMER_EN],
						q.irq_ctrl[cis_pkg::BIT_EXT_EN]}; // R5
				end
			end
			cis_pkg::ST_SLEEP: begin
				if (wake_cond) begin
					next_q.st = cis_pkg::ST_WAKE; // R5
				end
			end
			cis_pkg::ST_WAKE: begin
				next_q.st = cis_pkg::ST_RUN; // R6
			end
			default: begin
				next_q.st = cis_pkg::ST_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			q            <= '0;
			q.st         <= cis_pkg::ST_RUN;
			q.irq_ctrl   <= cis_pkg::IRQ_CTRL_RST;
			q.edge_pol   <= cis_pkg::EDGE_POL_RST;
			q.evt_mask   <= cis_pkg::EVT_MASK_RST;
		end else begin
			q <= next_q;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	ext_edge_dir_a: assert property (ext_hit |-> ($past(q.edge_pol) ? // R1
		($past(ext_irq_pin) && !$past(ext_irq_pin, 2)) : (!$past(ext_irq_pin) && $past(ext_irq_pin, 2))))
		else $error("external edge of wrong direction");

	ext_flag_set_a: assert property (ext_hit |=> q.irq_ctrl[cis_pkg::BIT_EXT_FLAG]) // R2
		else $error("external flag not set after edge");

	ext_disable_a: assert property (!q.irq_ctrl[cis_pkg::BIT_EXT_EN] && !pend_timer && !pend_port && !pend_aux // R3
		|-> !irq_req) else $error("request raised with external source disabled");

	sleep_wake_a: assert property ((q.st == cis_pkg::ST_SLEEP) && q.sleep_en[0] // R5
		&& q.irq_ctrl[cis_pkg::BIT_EXT_FLAG] |=> wake ##1 (q.st == cis_pkg::ST_RUN))
		else $error("enabled external flag did not wake");

	wake_branch_a: assert property (wake |-> (wake_to_vector == q.irq_ctrl[cis_pkg::BIT_GLOBAL_EN]) // R6
		&& $past(q.st) == cis_pkg::ST_SLEEP) else $error("wake branch decision wrong");

	timer_flag_a: assert property (timer_ovf |=> q.irq_ctrl[cis_pkg::BIT_TIMER_FLAG] // R7
		&& $past(eight_bit_timer_count) == cis_pkg::TIMER_ZERO) else $error("overflow flag not set");

	timer_enable_a: assert property (q.irq_ctrl[cis_pkg::BIT_TIMER_FLAG] && q.irq_ctrl[cis_pkg::BIT_TIMER_EN] // R8
		&& global_en |-> irq_req) else $error("enabled overflow gave no request");

	port_flag_a: assert property ($changed(upper_nibble_port) && $past(!reset) |=> ##1 // R9
		q.irq_ctrl[cis_pkg::BIT_PORT_FLAG]) else $error("port change flag not set");

	port_enable_a: assert property (q.irq_ctrl[cis_pkg::BIT_PORT_FLAG] && q.irq_ctrl[cis_pkg::BIT_PORT_EN] // R10
		&& global_en |-> irq_req) else $error("enabled port change gave no request");

	vector_load_a: assert property (irq_ack |=> pc_load && vector_pc == cis_pkg::IRQ_VECTOR // R15
		&& stack_top == $past(return_pc) && !global_en) else $error("vector not loaded on accept");

	request_gate_a: assert property (irq_req |-> global_en && any_pend) // R16
		else $error("request without global enable");

	aux_source_a: assert property (q.irq_ctrl[cis_pkg::BIT_GLOBAL_EN] && |(aux_flags & aux_enables) |-> irq_req) // R14
		else $error("auxiliary source ignored");

	// Status, read data, flag and sleep checks; a same-cycle event must survive a clear
	status_clear_a: assert property (bus.rd && (bus.addr == cis_pkg::ADDR_EVT_STATUS) && !ext_hit && !timer_ovf
		&& !port_hit && !wake |=> q.evt_status == 4'h0) else $error("event status not cleared by read");

	status_keep_a: assert property (ext_hit |=> q.evt_status[cis_pkg::EVT_EXT])
		else $error("pin event lost from status");

	mask_zero_a: assert property (bus.wr && (bus.addr == cis_pkg::ADDR_EVT_MASK) && (bus.wdata[3:0] == 4'h0)
		|=> !irq_out) else $error("line high with all events masked");

	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");

	load_pulse_a: assert property (pc_load |-> $past(irq_ack)) // R15
		else $error("vector load without accept");

	flag_sticky_a: assert property (q.irq_ctrl[cis_pkg::BIT_EXT_FLAG] // R2
		&& !(bus.wr && (bus.addr == cis_pkg::ADDR_IRQ_CTRL)) |=> q.irq_ctrl[cis_pkg::BIT_EXT_FLAG])
		else $error("external flag cleared by hardware");

	sleep_hold_a: assert property ((q.st == cis_pkg::ST_SLEEP) && !wake_cond |=> (q.st == cis_pkg::ST_SLEEP)) // R5
		else $error("left sleep without enabled flag");

	timer_hold_a: assert property ($past(eight_bit_timer_count) != cis_pkg::TIMER_MAX |-> !timer_ovf) // R7
		else $error("overflow without maximum count");

	wake_one_a: assert property (wake |=> !wake) // R6
		else $error("wake longer than one cycle");

	wake_cover: cover property ((q.st == cis_pkg::ST_SLEEP) ##1 wake_to_vector);
	vector_cover: cover property (irq_req ##[1:4] irq_ack ##1 pc_load);
	timer_cover: cover property (timer_ovf ##2 irq_out);

endmodule // cis_irq_sources

// File: cis_pkg.sv
package cis_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] ADDR_IRQ_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_OPTION      = 8'h01;
	localparam logic [7:0] ADDR_EVT_STATUS  = 8'h02;
	localparam logic [7:0] ADDR_EVT_MASK    = 8'h03;
	localparam logic [7:0] ADDR_CORE_STATE  = 8'h04;

	// Interrupt control register fields
	localparam int BIT_PORT_FLAG   = 0;
	localparam int BIT_EXT_FLAG    = 1;
	localparam int BIT_TIMER_FLAG  = 2;
	localparam int BIT_PORT_EN     = 3;
	localparam int BIT_EXT_EN      = 4;
	localparam int BIT_TIMER_EN    = 5;
	localparam int BIT_GLOBAL_EN   = 7;

	// Option register field
	localparam int BIT_EDGE_POL    = 6;

	// Event status and mask fields
	localparam int EVT_EXT         = 0;
	localparam int EVT_TIMER       = 1;
	localparam int EVT_PORT        = 2;
	localparam int EVT_WAKE        = 3;

	// Reset values
	localparam logic [7:0] IRQ_CTRL_RST  = 8'h00;
	localparam logic       EDGE_POL_RST  = 1'b0;
	localparam logic [3:0] EVT_MASK_RST  = 4'h0;

	// Core and stack figures
	localparam int         PC_W            = 13;
	localparam int         STACK_DEPTH     = 8;
	localparam int         STACK_PTR_W     = 3;
	localparam int         NUM_IRQ_SOURCES = 14;
	localparam int         NUM_AUX_SOURCES = NUM_IRQ_SOURCES - 3;
	localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
	localparam logic [7:0] TIMER_MAX       = 8'hFF;
	localparam logic [7:0] TIMER_ZERO      = 8'h00;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_SLEEP = 3'b010,
		ST_WAKE  = 3'b100
	} cis_state_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cis_regbus_t;

	// Requests from the core sequencer
	typedef struct packed {
		logic            sleep_enter;
		logic            irq_ack;
		logic            call_push;
		logic            ret_pop;
		logic [12:0]     pc;
	} cis_core_req_t;

endpackage

// File: cis_change_detect.sv
`timescale 1ns/1ps

module cis_change_detect #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Sampled lines and edge selection
	input  wire logic [W-1:0] sig,
	input  wire logic         rise_en,
	input  wire logic         fall_en,
	// Registered detection pulse
	output logic              hit
);

	typedef struct packed {
		logic [W-1:0] prev;
		logic         primed;
		logic         hit;
	} cis_det_state_t;

	cis_det_state_t q;
	cis_det_state_t next_q;

	// First sample after reset only loads history, so a pin already high is no edge
	always_comb begin
		next_q        = q;
		next_q.prev   = sig;
		next_q.primed = 1'b1;
		next_q.hit    = q.primed & (|((sig & ~q.prev & {W{rise_en}}) | (~sig & q.prev & {W{fall_en}})));
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign hit = q.hit;

endmodule // cis_change_detect

// File: cis_return_stack.sv
`timescale 1ns/1ps

module cis_return_stack (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Push and pop
	input  wire logic        push,
	input  wire logic        pop,
	input  wire logic [12:0] push_data,
	// Registered top of stack and fill level
	output logic [12:0]      top,
	output logic [3:0]       level
);

	typedef struct packed {
		logic [cis_pkg::STACK_DEPTH-1:0][12:0] entry; // R13
		logic [cis_pkg::STACK_PTR_W-1:0]       ptr;
		logic [3:0]                            level;
		logic [12:0]                           top;
	} cis_stk_state_t;

	cis_stk_state_t q;
	cis_stk_state_t next_q;

	// Pointer wraps like a ring: a ninth push silently overwrites the oldest entry
	always_comb begin
		next_q = q;
		if (push) begin
			next_q.entry[q.ptr] = push_data;
			next_q.ptr          = q.ptr + 3'h1;
			next_q.top          = push_data;
			if (q.level != 4'(cis_pkg::STACK_DEPTH)) begin
				next_q.level = q.level + 4'h1;
			end
		end else if (pop) begin
			next_q.ptr = q.ptr - 3'h1;
			next_q.top = q.entry[q.ptr - 3'h2];
			if (q.level != 4'h0) begin
				next_q.level = q.level - 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign top   = q.top;
	assign level = q.level;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	stack_depth_a: assert property (level <= 4'h8) else $error("stack level beyond eight"); // R13
	stack_push_top_a: assert property (push |=> top == $past(push_data)) else $error("top not pushed value"); // R11
	stack_fill_cover: cover property (level == 4'h8);

endmodule // cis_return_stack

// File: cis_core_model.sv
`timescale 1ns/1ps

// Core sequencer stand-in: takes one pending request, then waits for the vector load
module cis_core_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Permission to take requests
	input  wire logic serve,
	// Request and answer from the block
	input  wire logic irq_req,
	input  wire logic pc_load,
	// Acknowledge and count of vector loads seen
	output logic      irq_ack,
	output int        loads
);
	logic       busy;
	logic [7:0] work_w;
	logic [7:0] saved_w;

	// Busy keeps a second acknowledge off the line until the vector has been loaded
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_ack <= 1'b0;
			busy    <= 1'b0;
			loads   <= 0;
			work_w  <= 8'h5A;
			saved_w <= 8'h00;
		end else begin
			irq_ack <= serve && irq_req && !busy && !irq_ack;
			if (irq_ack) begin
				busy    <= 1'b1;
				saved_w <= work_w;
			end
			if (pc_load) begin
				busy   <= 1'b0;
				loads  <= loads + 1;
				work_w <= saved_w;
			end
		end
	end
endmodule // cis_core_model

// File: cis_irq_sources_bench.sv
`timescale 1ns/1ps

module cis_irq_sources_bench;
	logic        clk;
	logic        reset;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        ext_irq_pin;
	logic [7:0]  eight_bit_timer_count;
	logic [7:4]  upper_nibble_port;
	logic [10:0] aux_flags;
	logic [10:0] aux_enables;
	logic        sleep_enter;
	logic        irq_ack;
	logic        call_push;
	logic        ret_pop;
	logic [12:0] return_pc;
	logic        irq_req;
	logic        wake;
	logic        wake_to_vector;
	logic        pc_load;
	logic [12:0] vector_pc;
	logic [12:0] stack_top;
	logic        irq_out;
	logic        serve;
	logic        saw_wake;
	logic        saw_vec;
	int          loads;
	int          num_errors;
	int          cmp_count;
	int          cycles;

	cis_irq_sources cis_irq_sources_i (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin),
		.eight_bit_timer_count(eight_bit_timer_count), .upper_nibble_port(upper_nibble_port),
		.aux_flags(aux_flags), .aux_enables(aux_enables), .sleep_enter(sleep_enter), .irq_ack(irq_ack),
		.call_push(call_push), .ret_pop(ret_pop), .return_pc(return_pc), .irq_req(irq_req), .wake(wake),
		.wake_to_vector(wake_to_vector), .pc_load(pc_load), .vector_pc(vector_pc), .stack_top(stack_top),
		.irq_out(irq_out));

	cis_core_model cis_core_model_i (.clk(clk), .reset(reset), .serve(serve), .irq_req(irq_req),
		.pc_load(pc_load), .irq_ack(irq_ack), .loads(loads));

	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Wake is a one-cycle pulse, so hold what it showed
	always @(posedge clk) begin
		if (wake) begin
			saw_wake <= 1'b1;
			saw_vec  <= wake_to_vector;
		end
	end

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk1(input string name, input logic exp, input logic got);
		chk(name, {12'h000, exp}, {12'h000, got});
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One idle edge after the strobe, so a check right after sees the written state
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		chk($sformatf("reg %h", a), {5'h00, e}, {5'h00, reg_rdata});
	endtask

	// Pin change, then time for detector and flag to settle
	task automatic set_pin(input logic v);
		@(posedge clk);
		ext_irq_pin <= v;
		step(4);
	endtask

	// Enter sleep with the given control value, then raise the pin
	task automatic nap(input logic [7:0] ctrl);
		wr(cis_pkg::ADDR_IRQ_CTRL, ctrl);
		set_pin(1'b0);
		@(posedge clk);
		saw_wake    <= 1'b0;
		sleep_enter <= 1'b1;
		@(posedge clk);
		sleep_enter <= 1'b0;
		set_pin(1'b1);
		step(1); // Held wake copies land one edge after the pulse
	endtask

	initial begin
		reset = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd, ext_irq_pin, eight_bit_timer_count} = '0;
		{upper_nibble_port, aux_flags, aux_enables, sleep_enter, call_push, ret_pop, return_pc} = '0;
		{serve, saw_wake, saw_vec} = '0;
		num_errors = 0;
		cmp_count = 0;
		cycles = 0;
		step(20);
		reset <= 1'b0;
		// Reset state and an unmapped address
		rd(cis_pkg::ADDR_IRQ_CTRL, cis_pkg::IRQ_CTRL_RST);
		rd(cis_pkg::ADDR_OPTION, 8'h00);
		rd(cis_pkg::ADDR_EVT_MASK, 8'h00);
		rd(cis_pkg::ADDR_CORE_STATE, 8'h10);
		rd(8'h05, 8'h00);
		// Pin edge polarity, falling first
		set_pin(1'b1);
		rd(cis_pkg::ADDR_IRQ_CTRL, 8'h00);
		set_pin(1'b0);
		rd(cis_pkg::ADDR_IRQ_CTRL, 8'h02);
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h00);
		wr(cis_pkg::ADDR_OPTION, 8'h40);
		rd(cis_pkg::ADDR_OPTION, 8'h40);
		set_pin(1'b1);
		rd(cis_pkg::ADDR_IRQ_CTRL, 8'h02);
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h00);
		set_pin(1'b0);
		rd(cis_pkg::ADDR_IRQ_CTRL, 8'h00);
		rd(cis_pkg::ADDR_EVT_STATUS, 8'h01);
		rd(cis_pkg::ADDR_EVT_STATUS, 8'h00);
		// Interrupt line: raise, mask, clear by reading
		wr(cis_pkg::ADDR_EVT_MASK, 8'h01);
		set_pin(1'b1);
		chk1("irq_out", 1'b1, irq_out);
		wr(cis_pkg::ADDR_EVT_MASK, 8'h00);
		chk1("irq_out", 1'b0, irq_out);
		wr(cis_pkg::ADDR_EVT_MASK, 8'h01);
		rd(cis_pkg::ADDR_EVT_STATUS, 8'h01);
		chk1("irq_out", 1'b0, irq_out);
		// Request gating of the pin flag
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h92);
		chk1("irq_req", 1'b1, irq_req);
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h82);
		chk1("irq_req", 1'b0, irq_req);
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h12);
		chk1("irq_req", 1'b0, irq_req);
		// Timer rollover only from the maximum
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h00);
		eight_bit_timer_count <= 8'hFE;
		step(2);
		eight_bit_timer_count <= cis_pkg::TIMER_MAX;
		step(3);
		rd(cis_pkg::ADDR_IRQ_CTRL, 8'h00);
		eight_bit_timer_count <= cis_pkg::TIMER_ZERO;
		step(3);
		rd(cis_pkg::ADDR_IRQ_CTRL, 8'h04);
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'hA4);
		chk1("irq_req", 1'b1, irq_req);
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h84);
		chk1("irq_req", 1'b0, irq_req);
		rd(cis_pkg::ADDR_EVT_STATUS, 8'h02);
		// Each upper port pin on its own
		for (int p = 4; p < 8; p++) begin
			wr(cis_pkg::ADDR_IRQ_CTRL, 8'h00);
			upper_nibble_port[p] <= ~upper_nibble_port[p];
			step(4);
			rd(cis_pkg::ADDR_IRQ_CTRL, 8'h01);
		end
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h89);
		chk1("irq_req", 1'b1, irq_req);
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h81);
		chk1("irq_req", 1'b0, irq_req);
		rd(cis_pkg::ADDR_EVT_STATUS, 8'h04);
		// Highest of the other sources, then a mismatched enable
		wr(cis_pkg::ADDR_IRQ_CTRL, 8'h80);
		aux_flags <= 11'h400;
		aux_enables <= 11'h400;
		step(2);
		chk1("irq_req", 1'b1, irq_req);
		aux_enables <= 11'h200;
		step(2);
		chk1("irq_req", 1'b0, irq_req);
		// Taking a request: vector, return address, global enable dropped
		aux_flags <= 11'h001;
		aux_enables <= 11'h001;
		return_pc <= 13'h0123;
		serve <= 1'b1;
		for (int i = 0; i < 20 && loads == 0; i++) step(1);
		chk("loads", 13'h0001, loads[12:0]);
		chk("vector_pc", cis_pkg::IRQ_VECTOR, vector_pc);
		chk("stack_top", 13'h0123, stack_top);
		rd(cis_pkg::ADDR_IRQ_CTRL, 8'h00);
		rd(cis_pkg::ADDR_CORE_STATE, 8'h11);
		serve <= 1'b0;
		aux_flags <= 11'h000;
		aux_enables <= 11'h000;
		// Nine back-to-back pushes saturate the level at eight
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			call_push <= 1'b1;
			return_pc <= 13'h0200 + 13'(i);
		end
		@(posedge clk);
		call_push <= 1'b0;
		rd(cis_pkg::ADDR_CORE_STATE, 8'h18);
		chk("stack_top", 13'h0208, stack_top);
		@(posedge clk);
		ret_pop <= 1'b1;
		@(posedge clk);
		ret_pop <= 1'b0;
		step(1);
		chk("stack_top", 13'h0207, stack_top);
		// Sleep: wake only with enable set beforehand, vector only with global enable
		nap(8'h10);
		chk1("saw_wake", 1'b1, saw_wake);
		chk1("saw_vec", 1'b0, saw_vec);
		rd(cis_pkg::ADDR_CORE_STATE, 8'h17);
		rd(cis_pkg::ADDR_EVT_STATUS, 8'h09);
		nap(8'h90);
		chk1("saw_wake", 1'b1, saw_wake);
		chk1("saw_vec", 1'b1, saw_vec);
		nap(8'h80);
		chk1("saw_wake", 1'b0, saw_wake);
		rd(cis_pkg::ADDR_CORE_STATE, 8'h27);
		// A second reset in mid-run
		reset <= 1'b1;
		step(2);
		reset <= 1'b0;
		rd(cis_pkg::ADDR_CORE_STATE, 8'h10);
		end_sim();
	end
endmodule // cis_irq_sources_bench
